// *** core/tdmh_slot_mapper.sv ***
// Top of the TDM highway slot mapper: APB registers, pin synchronisers and slot datapaths.
//
// Behaviour
// - Transmit bits launch on falling highway clock edge, or rising when edge bit set.
// - Receive bits sampled on falling highway clock edge, or rising when edge bit set.
// - Per-slot transmit enable; disabled slot leaves the lane in high impedance.
// - Per-slot receive enable; disabled slot ignores highway and delivers idle code.
// - Per-slot transmit lane select: 0 primary lane, 1 secondary lane.
// - Per-slot receive lane select: 0 primary lane, 1 secondary lane.
// - Transmit bit offset delays slot 0 by highway clock cycles after sync.
// - Receive bit offset delays slot 0 by highway clock cycles after sync.
// - Transmit byte offset shifts frame start by whole bytes, range set by rate.
// - Receive byte offset shifts frame start by whole bytes, range set by rate.
// - Byte offsets are capped at a 64-byte frame with signalling; otherwise the rate alone sets the range.
// - Signalling mode slots hold 16 bits: payload octet then signalling octet.
// - Stuffed-slot field places eight unused slots; effective only in T1 framing.
// - Normal frame holds 32 contiguous slots; DS1 has 24 payload, eight stuffed.
// - E1 framing uses all 32 slots for payload, none stuffed.
// - Double-slot mode alternates payload and idle slots; higher rates only.
// - Signalling mode without double-slot: 32 contiguous two-octet slots, DS1 stuffs eight.
// - Signalling plus double-slot: alternate slots high impedance out, ignored in.
// - First-bit edge counts run from the edge where frame sync is sampled.
// - Zero byte offset: 4 plus twice bit offset if edges match, else 3 plus twice bit offset.
// - Frame sync sampled on falling edge, or rising when frame-edge bit set.
// - Rate field: 00 base, 01 double, 10 quadruple rate.
`timescale 1ns/1ps
module tdmh_slot_mapper (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic HIGHWAY_CLOCK_IN,
  input wire logic TX_FRAME_SYNC_IN,
  input wire logic RX_FRAME_SYNC_IN,
  output logic TX_LANE_PRIMARY_OUT,
  output logic TX_LANE_PRIMARY_OE_OUT,
  output logic TX_LANE_SECONDARY_OUT,
  output logic TX_LANE_SECONDARY_OE_OUT,
  input wire logic RX_LANE_PRIMARY_IN,
  input wire logic RX_LANE_SECONDARY_IN,
  input wire logic TX_PAYLOAD_WR_IN,
  input wire logic [4:0] TX_PAYLOAD_SLOT_IN,
  input wire logic [15:0] TX_PAYLOAD_DATA_IN,
  output logic RX_PAYLOAD_VALID_OUT,
  output logic [4:0] RX_PAYLOAD_SLOT_OUT,
  output logic [15:0] RX_PAYLOAD_DATA_OUT
);

  typedef struct packed {
    logic apb_ready;
    logic apb_err;
    logic [31:0] apb_rdata;
    logic [tdmh_pkg::CTRL_W-1:0] ctrl;
    logic [tdmh_pkg::TIM_W-1:0] tx_tim;
    logic [tdmh_pkg::TIM_W-1:0] rx_tim;
    logic [31:0] tx_slot_enable;
    logic [31:0] rx_slot_enable;
    logic [31:0] tx_lane_select;
    logic [31:0] rx_lane_select;
    logic [tdmh_pkg::IDLE_W-1:0] idle_code;
    logic [2:0] hc_meta;
    logic [2:0] hc_sync;
    logic hc_prev;
    logic [1:0] rx_meta;
    logic [1:0] rx_sync;
    logic tx_pri;
    logic tx_pri_oe;
    logic tx_sec;
    logic tx_sec_oe;
    logic [tdmh_pkg::WORD_W-1:0] rx_shift;
    logic rx_valid;
    logic [tdmh_pkg::SLOT_W-1:0] rx_slot;
    logic [tdmh_pkg::WORD_W-1:0] rx_data;
  } tdmh_top_regs_t;

  localparam tdmh_top_regs_t TOP_RST = '{ctrl: tdmh_pkg::CTRL_RST, tx_tim: tdmh_pkg::TIM_RST,
                                         rx_tim: tdmh_pkg::TIM_RST, idle_code: tdmh_pkg::IDLE_RST,
                                         default: '0};

  tdmh_top_regs_t q;
  tdmh_top_regs_t d;

  tdmh_timer_if tx_tif ();
  tdmh_timer_if rx_tif ();
  tdmh_mem_if tx_mif ();

  logic rise;
  logic fall;
  logic [1:0] rate;
  logic assoc;
  logic t1_mode;
  logic [2:0] stuff_pos;
  logic tx_dbl;
  logic rx_dbl;
  logic [6:0] byoff_max;
  logic tx_edge;
  logic rx_edge;
  logic [tdmh_pkg::BIT_W-1:0] last_bit;
  logic [tdmh_pkg::SLOT_W-1:0] tx_slot;
  logic [tdmh_pkg::SLOT_W-1:0] rx_slot;
  logic tx_in_slot;
  logic rx_in_slot;
  logic [tdmh_pkg::WORD_W-1:0] tx_word;
  logic [tdmh_pkg::WORD_W-1:0] idle_word;
  logic tx_bit;
  logic rx_bit;
  logic apb_access;
  logic addr_hit;
  logic [31:0] rd_value;

  // Returns true when a highway slot is one of the eight stuffed slots of a T1 frame.
  function automatic logic slot_stuffed(input logic t1, input logic [2:0] pos, input logic [4:0] slot);
    logic hit;
    hit = 1'b0;
    if (t1) begin
      if (pos >= tdmh_pkg::STUFF_GROUPED) begin
        hit = (slot >= tdmh_pkg::STUFF_GROUP_FIRST);
      end else begin
        hit = (slot[1:0] == pos[1:0]);
      end
    end
    return hit;
  endfunction

  // Maps a timer interval to a payload slot; in double-slot mode odd intervals are holes.
  function automatic logic ivl_in_slot(input logic dbl, input logic [6:0] ivl);
    logic ok;
    ok = dbl ? (ivl[0] == 1'b0) && (ivl[6] == 1'b0) : (ivl[6:5] == 2'h0);
    return ok;
  endfunction

  // Control fields; double-slot mode is honoured only above the base rate.
  assign rate = q.ctrl[tdmh_pkg::RATE_LSB +: 2];
  assign assoc = q.ctrl[tdmh_pkg::ASSOC_BIT];
  assign t1_mode = q.ctrl[tdmh_pkg::T1_BIT];
  assign stuff_pos = q.ctrl[tdmh_pkg::STUFF_LSB +: 3];
  assign tx_dbl = q.ctrl[tdmh_pkg::TX_DBL_BIT] & (rate != tdmh_pkg::RATE_BASE);
  assign rx_dbl = q.ctrl[tdmh_pkg::RX_DBL_BIT] & (rate != tdmh_pkg::RATE_BASE);
  assign last_bit = assoc ? tdmh_pkg::LAST_BIT_ASSOC : tdmh_pkg::LAST_BIT_NORM;
  assign idle_word = {q.idle_code, q.idle_code};

  // Byte offset range allowed at the chosen rate and frame size.
  always_comb begin
    unique case (rate)
      tdmh_pkg::RATE_DBL: byoff_max = tdmh_pkg::BYOFF_MAX_DBL;
      tdmh_pkg::RATE_QUAD: byoff_max = tdmh_pkg::BYOFF_MAX_QUAD;
      default: byoff_max = tdmh_pkg::BYOFF_MAX_BASE;
    endcase
    if (assoc) begin
      byoff_max = byoff_max & tdmh_pkg::BYOFF_MAX_ASSOC;
    end
  end

  // Highway clock edges seen after the two-stage synchroniser.
  // A false edge just after reset is harmless, since both timers idle until a sync.
  assign rise = q.hc_sync[0] & ~q.hc_prev;
  assign fall = ~q.hc_sync[0] & q.hc_prev;

  // Transmit timer configuration.
  assign tx_tif.rise = rise;
  assign tx_tif.fall = fall;
  assign tx_tif.sync = q.hc_sync[1];
  assign tx_tif.sync_edge_sel = q.tx_tim[tdmh_pkg::SYNC_EDGE_BIT];
  assign tx_tif.data_edge_sel = q.tx_tim[tdmh_pkg::DATA_EDGE_BIT];
  assign tx_tif.assoc = assoc;
  assign tx_tif.bit_offset = q.tx_tim[tdmh_pkg::BITOFF_LSB +: 3];
  assign tx_tif.byte_offset = q.tx_tim[tdmh_pkg::BYTEOFF_LSB +: 7] & byoff_max;

  // Receive timer configuration.
  assign rx_tif.rise = rise;
  assign rx_tif.fall = fall;
  assign rx_tif.sync = q.hc_sync[2];
  assign rx_tif.sync_edge_sel = q.rx_tim[tdmh_pkg::SYNC_EDGE_BIT];
  assign rx_tif.data_edge_sel = q.rx_tim[tdmh_pkg::DATA_EDGE_BIT];
  assign rx_tif.assoc = assoc;
  assign rx_tif.bit_offset = q.rx_tim[tdmh_pkg::BITOFF_LSB +: 3];
  assign rx_tif.byte_offset = q.rx_tim[tdmh_pkg::BYTEOFF_LSB +: 7] & byoff_max;

  tdmh_slot_timer u_tx_timer (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .tif(tx_tif)
  );

  tdmh_slot_timer u_rx_timer (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .tif(rx_tif)
  );

  // Framer writes the payload store; the transmit timer's slot addresses the read side.
  // The registered read is safe: a slot address settles long before its first launch edge.
  assign tx_mif.wr_en = TX_PAYLOAD_WR_IN;
  assign tx_mif.wr_addr = TX_PAYLOAD_SLOT_IN;
  assign tx_mif.wr_data = TX_PAYLOAD_DATA_IN;
  assign tx_mif.rd_addr = tx_slot;

  tdmh_slot_mem u_tx_mem (
    .clk_in(CLK_IN),
    .ce_in(CE_IN),
    .mif(tx_mif)
  );

  // Slot decoding for both directions.
  assign tx_edge = tx_tif.data_edge_sel ? rise : fall;
  assign rx_edge = rx_tif.data_edge_sel ? rise : fall;
  assign tx_slot = tx_dbl ? tx_tif.interval[5:1] : tx_tif.interval[4:0];
  assign rx_slot = rx_dbl ? rx_tif.interval[5:1] : rx_tif.interval[4:0];
  assign tx_in_slot = tx_tif.running & ivl_in_slot(tx_dbl, tx_tif.interval);
  assign rx_in_slot = rx_tif.running & ivl_in_slot(rx_dbl, rx_tif.interval);

  // Stuffed slots send the idle code; bits leave most significant first.
  assign tx_word = slot_stuffed(t1_mode, stuff_pos, tx_slot) ? idle_word : tx_mif.rd_data;
  assign tx_bit = tx_word[last_bit - tx_tif.bit_idx];
  assign rx_bit = q.rx_lane_select[rx_slot] ? q.rx_sync[1] : q.rx_sync[0];

  // Register decode and read mux.
  assign apb_access = PSEL_IN & PENABLE_IN;

  // Read mux; an address outside the map flags a bus error.
  always_comb begin
    addr_hit = 1'b1;
    rd_value = '0;
    unique case (PADDR_IN)
      tdmh_pkg::ADDR_CTRL: rd_value = {23'h000000, q.ctrl};
      tdmh_pkg::ADDR_TX_TIM: rd_value = {17'h00000, q.tx_tim};
      tdmh_pkg::ADDR_RX_TIM: rd_value = {17'h00000, q.rx_tim};
      tdmh_pkg::ADDR_TX_EN: rd_value = q.tx_slot_enable;
      tdmh_pkg::ADDR_RX_EN: rd_value = q.rx_slot_enable;
      tdmh_pkg::ADDR_TX_LANE: rd_value = q.tx_lane_select;
      tdmh_pkg::ADDR_RX_LANE: rd_value = q.rx_lane_select;
      tdmh_pkg::ADDR_IDLE: rd_value = {24'h000000, q.idle_code};
      tdmh_pkg::ADDR_STATUS: begin
        rd_value[tdmh_pkg::ST_RX_IVL_LSB +: tdmh_pkg::IVL_W] = rx_tif.interval;
        rd_value[tdmh_pkg::ST_TX_IVL_LSB +: tdmh_pkg::IVL_W] = tx_tif.interval;
        rd_value[tdmh_pkg::ST_RX_RUN_BIT] = rx_tif.running;
        rd_value[tdmh_pkg::ST_TX_RUN_BIT] = tx_tif.running;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // Next state of everything the top module holds.
  always_comb begin
    d = q;

    // Pin synchronisers; sync pins ride with the clock so their stages stay aligned.
    d.hc_meta = {RX_FRAME_SYNC_IN, TX_FRAME_SYNC_IN, HIGHWAY_CLOCK_IN};
    d.hc_sync = q.hc_meta;
    d.hc_prev = q.hc_sync[0];
    d.rx_meta = {RX_LANE_SECONDARY_IN, RX_LANE_PRIMARY_IN};
    d.rx_sync = q.rx_meta;

    // APB slave: one wait state, write applied at the completing edge.
    if (apb_access & ~q.apb_ready) begin
      d.apb_ready = 1'b1;
      d.apb_err = ~addr_hit;
      d.apb_rdata = PWRITE_IN ? 32'h00000000 : rd_value;
    end else begin
      d.apb_ready = 1'b0;
      d.apb_err = 1'b0;
      if (apb_access & PWRITE_IN & addr_hit) begin
        unique case (PADDR_IN)
          tdmh_pkg::ADDR_CTRL: d.ctrl = PWDATA_IN[tdmh_pkg::CTRL_W-1:0];
          tdmh_pkg::ADDR_TX_TIM: d.tx_tim = PWDATA_IN[tdmh_pkg::TIM_W-1:0];
          tdmh_pkg::ADDR_RX_TIM: d.rx_tim = PWDATA_IN[tdmh_pkg::TIM_W-1:0];
          tdmh_pkg::ADDR_TX_EN: d.tx_slot_enable = PWDATA_IN;
          tdmh_pkg::ADDR_RX_EN: d.rx_slot_enable = PWDATA_IN;
          tdmh_pkg::ADDR_TX_LANE: d.tx_lane_select = PWDATA_IN;
          tdmh_pkg::ADDR_RX_LANE: d.rx_lane_select = PWDATA_IN;
          tdmh_pkg::ADDR_IDLE: d.idle_code = PWDATA_IN[tdmh_pkg::IDLE_W-1:0];
          default: d.apb_err = 1'b0;
        endcase
      end
    end

    // Transmit lanes change only on the launch edge; holes and disabled slots float.
    if (tx_edge) begin
      d.tx_pri_oe = 1'b0;
      d.tx_sec_oe = 1'b0;
      if (tx_in_slot & q.tx_slot_enable[tx_slot]) begin
        if (q.tx_lane_select[tx_slot]) begin
          d.tx_sec = tx_bit;
          d.tx_sec_oe = 1'b1;
        end else begin
          d.tx_pri = tx_bit;
          d.tx_pri_oe = 1'b1;
        end
      end
    end

    // Receive: shift in on the sample edge, hand a word over after the last bit.
    d.rx_valid = 1'b0;
    if (rx_edge & rx_in_slot) begin
      d.rx_shift = {q.rx_shift[tdmh_pkg::WORD_W-2:0], rx_bit};
      if (rx_tif.bit_idx == last_bit) begin
        if (!slot_stuffed(t1_mode, stuff_pos, rx_slot)) begin
          d.rx_slot = rx_slot;
          d.rx_valid = 1'b1;
          if (q.rx_slot_enable[rx_slot]) begin
            d.rx_data = d.rx_shift & (assoc ? 16'hFFFF : 16'h00FF);
          end else begin
            d.rx_data = assoc ? idle_word : {8'h00, q.idle_code};
          end
        end
      end
    end
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      q <= TOP_RST;
    end else if (CE_IN) begin
      q <= d;
    end
  end

  assign PRDATA_OUT = q.apb_rdata;
  assign PREADY_OUT = q.apb_ready;
  assign PSLVERR_OUT = q.apb_err;
  assign TX_LANE_PRIMARY_OUT = q.tx_pri;
  assign TX_LANE_PRIMARY_OE_OUT = q.tx_pri_oe;
  assign TX_LANE_SECONDARY_OUT = q.tx_sec;
  assign TX_LANE_SECONDARY_OE_OUT = q.tx_sec_oe;
  assign RX_PAYLOAD_VALID_OUT = q.rx_valid;
  assign RX_PAYLOAD_SLOT_OUT = q.rx_slot;
  assign RX_PAYLOAD_DATA_OUT = q.rx_data;

endmodule

// *** shared/tdmh_pkg.sv ***
// Shared constants, register map and types for the TDM highway slot mapper.
package tdmh_pkg;

  // Structural sizes.
  localparam int unsigned SLOTS = 32;
  localparam int unsigned SLOT_W = 5;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned EDGE_W = 12;
  localparam int unsigned IVL_W = 7;
  localparam int unsigned BIT_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CTRL_W = 9;
  localparam int unsigned TIM_W = 15;
  localparam int unsigned IDLE_W = 8;

  // APB byte addresses of the registers.
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TX_TIM = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RX_TIM = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TX_EN = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_RX_EN = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_TX_LANE = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_RX_LANE = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IDLE = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;

  // Control register fields.
  localparam int unsigned RATE_LSB = 0;
  localparam int unsigned ASSOC_BIT = 2;
  localparam int unsigned TX_DBL_BIT = 3;
  localparam int unsigned RX_DBL_BIT = 4;
  localparam int unsigned T1_BIT = 5;
  localparam int unsigned STUFF_LSB = 6;

  // Timing register fields, same layout for both directions.
  localparam int unsigned BITOFF_LSB = 0;
  localparam int unsigned SYNC_EDGE_BIT = 3;
  localparam int unsigned DATA_EDGE_BIT = 6;
  localparam int unsigned BYTEOFF_LSB = 8;

  // Status register fields.
  localparam int unsigned ST_RX_IVL_LSB = 0;
  localparam int unsigned ST_TX_IVL_LSB = 8;
  localparam int unsigned ST_RX_RUN_BIT = 16;
  localparam int unsigned ST_TX_RUN_BIT = 17;

  // Highway rate codes.
  localparam logic [1:0] RATE_BASE = 2'h0;
  localparam logic [1:0] RATE_DBL = 2'h1;
  localparam logic [1:0] RATE_QUAD = 2'h2;

  // Byte offset limits per rate and for the 64-byte signalling frame.
  localparam logic [6:0] BYOFF_MAX_BASE = 7'h1F;
  localparam logic [6:0] BYOFF_MAX_DBL = 7'h3F;
  localparam logic [6:0] BYOFF_MAX_QUAD = 7'h7F;
  localparam logic [6:0] BYOFF_MAX_ASSOC = 7'h3F;

  // First-bit edge counts for zero offsets.
  localparam logic [EDGE_W-1:0] CE_MATCH = 12'h004;
  localparam logic [EDGE_W-1:0] CE_DIFF = 12'h003;
  localparam logic [EDGE_W-1:0] CE_ARM = 12'h002;

  // Byte offset to edge count shifts: two edges per bit, 8 or 16 bits per slot.
  localparam int unsigned EDGE_SHIFT_NORM = 4;
  localparam int unsigned EDGE_SHIFT_ASSOC = 5;

  // Last bit index of a slot.
  localparam logic [BIT_W-1:0] LAST_BIT_NORM = 4'h7;
  localparam logic [BIT_W-1:0] LAST_BIT_ASSOC = 4'hF;
  localparam logic [IVL_W-1:0] IVL_LAST = 7'h7F;

  // Stuffed slot placement for T1 framing.
  localparam logic [2:0] STUFF_GROUPED = 3'h4;
  localparam logic [SLOT_W-1:0] STUFF_GROUP_FIRST = 5'h18;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [TIM_W-1:0] TIM_RST = 15'h0000;
  localparam logic [IDLE_W-1:0] IDLE_RST = 8'hFF;

  // Slot timer states.
  typedef enum logic [2:0] {
    TM_IDLE = 3'b001,
    TM_LEAD = 3'b010,
    TM_RUN = 3'b100
  } tdmh_tm_state_t;

endpackage

// *** shared/tdmh_if.sv ***
// Interfaces between the slot mapper and its slot timers and transmit memory.
`timescale 1ns/1ps
interface tdmh_timer_if;
  logic rise;
  logic fall;
  logic sync;
  logic sync_edge_sel;
  logic data_edge_sel;
  logic assoc;
  logic [2:0] bit_offset;
  logic [6:0] byte_offset;
  logic running;
  logic [tdmh_pkg::IVL_W-1:0] interval;
  logic [tdmh_pkg::BIT_W-1:0] bit_idx;
  modport ctrl (output rise, fall, sync, sync_edge_sel, data_edge_sel, assoc, bit_offset, byte_offset,
                input running, interval, bit_idx);
  modport timer (input rise, fall, sync, sync_edge_sel, data_edge_sel, assoc, bit_offset, byte_offset,
                 output running, interval, bit_idx);
endinterface

interface tdmh_mem_if;
  logic wr_en;
  logic [tdmh_pkg::SLOT_W-1:0] wr_addr;
  logic [tdmh_pkg::WORD_W-1:0] wr_data;
  logic [tdmh_pkg::SLOT_W-1:0] rd_addr;
  logic [tdmh_pkg::WORD_W-1:0] rd_data;
  modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// *** core/tdmh_slot_mem.sv ***
// Transmit payload store: one word per highway slot, registered read.
`timescale 1ns/1ps
module tdmh_slot_mem (
  input wire logic clk_in,
  input wire logic ce_in,
  tdmh_mem_if.mem mif
);

  typedef struct packed {
    logic [tdmh_pkg::SLOTS-1:0][tdmh_pkg::WORD_W-1:0] words;
    logic [tdmh_pkg::WORD_W-1:0] rd_data;
  } tdmh_mem_regs_t;

  tdmh_mem_regs_t q;
  tdmh_mem_regs_t d;

  // Write the addressed word and register the read word.
  always_comb begin
    d = q;
    if (mif.wr_en) begin
      d.words[mif.wr_addr] = mif.wr_data;
    end
    d.rd_data = q.words[mif.rd_addr];
  end

  // Storage has no reset; contents are undefined until the framer writes them.
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      q <= d;
    end
  end

  assign mif.rd_data = q.rd_data;

endmodule

// *** core/tdmh_slot_timer.sv ***
// Slot timer: counts highway edges from the sampled frame sync to slot 0, then walks bits.
`timescale 1ns/1ps
module tdmh_slot_timer (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  tdmh_timer_if.timer tif
);

  typedef struct packed {
    tdmh_pkg::tdmh_tm_state_t st;
    logic [tdmh_pkg::EDGE_W-1:0] cnt;
    logic [tdmh_pkg::IVL_W-1:0] ivl;
    logic [tdmh_pkg::BIT_W-1:0] bitn;
    logic sync_prev;
  } tdmh_tm_regs_t;

  localparam tdmh_tm_regs_t TM_RST = '{st: tdmh_pkg::TM_IDLE, default: '0};

  tdmh_tm_regs_t q;
  tdmh_tm_regs_t d;
  logic sync_edge;
  logic data_edge;
  logic sync_hit;
  logic [tdmh_pkg::EDGE_W-1:0] lead;
  logic [tdmh_pkg::EDGE_W-1:0] byte_edges;
  logic [tdmh_pkg::BIT_W-1:0] last_bit;

  // Edge choice for sync sampling and data; a sync counts only on its rising level.
  assign sync_edge = tif.sync_edge_sel ? tif.rise : tif.fall;
  assign data_edge = tif.data_edge_sel ? tif.rise : tif.fall;
  assign sync_hit = sync_edge & tif.sync & ~q.sync_prev;
  assign last_bit = tif.assoc ? tdmh_pkg::LAST_BIT_ASSOC : tdmh_pkg::LAST_BIT_NORM;

  // Edges from the sync edge to bit 0 of slot 0.
  always_comb begin
    byte_edges = tif.assoc ? (tdmh_pkg::EDGE_W)'({5'h00, tif.byte_offset} << tdmh_pkg::EDGE_SHIFT_ASSOC)
                           : (tdmh_pkg::EDGE_W)'({5'h00, tif.byte_offset} << tdmh_pkg::EDGE_SHIFT_NORM);
    lead = (tif.sync_edge_sel == tif.data_edge_sel) ? tdmh_pkg::CE_MATCH : tdmh_pkg::CE_DIFF;
    lead = lead + {8'h00, tif.bit_offset, 1'b0} + byte_edges;
  end

  // Lead-in countdown, then one bit per data edge across the frame.
  always_comb begin
    d = q;
    if (sync_edge) begin
      d.sync_prev = tif.sync;
    end
    if (sync_hit) begin
      d.st = tdmh_pkg::TM_LEAD;
      d.cnt = lead;
      d.ivl = '0;
      d.bitn = '0;
    end else begin
      unique case (q.st)
        tdmh_pkg::TM_IDLE: begin
          d.st = tdmh_pkg::TM_IDLE;
        end
        tdmh_pkg::TM_LEAD: begin
          if (tif.rise | tif.fall) begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == tdmh_pkg::CE_ARM) begin
              d.st = tdmh_pkg::TM_RUN;
            end
          end
        end
        tdmh_pkg::TM_RUN: begin
          if (data_edge) begin
            if (q.bitn == last_bit) begin
              d.bitn = '0;
              if (q.ivl == tdmh_pkg::IVL_LAST) begin
                d.st = tdmh_pkg::TM_IDLE;
              end else begin
                d.ivl = q.ivl + 1'b1;
              end
            end else begin
              d.bitn = q.bitn + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // State register with clock enable.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      q <= TM_RST;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign tif.running = (q.st == tdmh_pkg::TM_RUN);
  assign tif.interval = q.ivl;
  assign tif.bit_idx = q.bitn;

endmodule

// *** tb/tdmh_checker.sv ***
// Port-level checks for the slot mapper.
`timescale 1ns/1ps
module tdmh_checker (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic TX_LANE_PRIMARY_OUT,
  input wire logic TX_LANE_PRIMARY_OE_OUT,
  input wire logic TX_LANE_SECONDARY_OE_OUT,
  input wire logic RX_PAYLOAD_VALID_OUT,
  input wire logic [15:0] RX_PAYLOAD_DATA_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Lanes move only on highway edges, many system cycles apart.
  a_lane_exclusive: assert property (!(TX_LANE_PRIMARY_OE_OUT && TX_LANE_SECONDARY_OE_OUT))
    else $error("both lanes driven");
  a_tx_data_hold: assert property ($changed(TX_LANE_PRIMARY_OUT) |=> $stable(TX_LANE_PRIMARY_OUT) [*8])
    else $error("lane data too short");
  a_tx_oe_hold: assert property ($changed(TX_LANE_PRIMARY_OE_OUT) |=> $stable(TX_LANE_PRIMARY_OE_OUT) [*8])
    else $error("lane enable too short");
  a_rx_pulse_gap: assert property (RX_PAYLOAD_VALID_OUT |=> !RX_PAYLOAD_VALID_OUT [*8])
    else $error("slot pulses too close");
  a_rx_data_hold: assert property (!RX_PAYLOAD_VALID_OUT |-> $stable(RX_PAYLOAD_DATA_OUT))
    else $error("slot data moved");
  // Bus answers one cycle after the access phase starts.
  a_ready_timing: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("ready late");
  a_ready_unasked: assert property (!(PSEL_IN && PENABLE_IN) |=> !PREADY_OUT)
    else $error("ready unasked");
  a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
endmodule
bind tdmh_slot_mapper tdmh_checker u_chk (.*);

// *** tb/tdmh_partner.sv ***
// Far-side highway model: clock, sync, receive lanes, transmit capture.
`timescale 1ns/1ps
module tdmh_partner (
  input wire logic run_in,
  input wire logic tx_in,
  input wire logic tx_oe_in,
  output logic hclk_out,
  output logic sync_out,
  output logic rxp_out,
  output logic rxs_out,
  output logic [7:0] txb_out,
  output logic oe_out
);
  int n = 0;
  int k;
  logic b;
  logic [7:0] p;
  initial begin
    {hclk_out, sync_out, rxp_out, rxs_out} = 4'h1;
  end
  // Free-running highway clock of 120 ns.
  always #60 hclk_out = ~hclk_out;
  // A 44-period frame; data changes on rising edges, so falling samples see it settled.
  always @(posedge hclk_out) begin
    n = (n == 43) ? 0 : n + 1;
    k = n - 2;
    sync_out <= run_in && n == 0;
    if (k >= 0 && k < 40) begin
      p = 8'hA5 ^ 8'(k / 8);
      b = p[7 - k % 8];
    end else begin
      b = ~rxp_out;
    end
    rxp_out <= b;
    rxs_out <= ~b;
    if (n >= 3 && n <= 10) txb_out <= {txb_out[6:0], tx_oe_in ? tx_in : 1'bx};
    if (n == 11) oe_out <= tx_oe_in;
  end
endmodule

// *** tb/tb.sv ***
// Bench: bus registers, then highway receive, transmit and reset.
`timescale 1ns/1ps
module tb;
  logic CLK_IN, RST_B_IN, CE_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT;
  logic [7:0] PADDR_IN;
  logic [31:0] PWDATA_IN, PRDATA_OUT, rd, seed = 32'hF059;
  logic HIGHWAY_CLOCK_IN, TX_FRAME_SYNC_IN, RX_FRAME_SYNC_IN, TX_LANE_PRIMARY_OUT, TX_LANE_PRIMARY_OE_OUT;
  logic TX_LANE_SECONDARY_OUT, TX_LANE_SECONDARY_OE_OUT, RX_LANE_PRIMARY_IN, RX_LANE_SECONDARY_IN;
  logic TX_PAYLOAD_WR_IN, RX_PAYLOAD_VALID_OUT, run, oe1, err;
  logic [4:0] TX_PAYLOAD_SLOT_IN, RX_PAYLOAD_SLOT_OUT;
  logic [15:0] TX_PAYLOAD_DATA_IN, RX_PAYLOAD_DATA_OUT;
  logic [7:0] txb, idle, p;
  logic [20:0] q[$];
  int mismatches = 0, n_tests = 0, cyc = 0, sl;
  tdmh_slot_mapper DUT (.*);
  tdmh_partner far (.run_in(run), .tx_in(TX_LANE_PRIMARY_OUT), .tx_oe_in(TX_LANE_PRIMARY_OE_OUT),
    .hclk_out(HIGHWAY_CLOCK_IN), .sync_out(RX_FRAME_SYNC_IN), .rxp_out(RX_LANE_PRIMARY_IN),
    .rxs_out(RX_LANE_SECONDARY_IN), .txb_out(txb), .oe_out(oe1));
  assign TX_FRAME_SYNC_IN = RX_FRAME_SYNC_IN;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One bus transfer; the request stands until ready is seen.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    do @(posedge CLK_IN); while (PREADY_OUT !== 1'b1);
    rd = PRDATA_OUT;
    err = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask
  initial begin
    CLK_IN = 1'b0;
    forever #2.5 CLK_IN = ~CLK_IN;
  end
  // Watchdog, and each receive pulse against the oldest note.
  always @(posedge CLK_IN) begin
    cyc <= cyc + 1;
    if (RX_PAYLOAD_VALID_OUT === 1'b1) begin
      if (q.size() == 0) chk("rx extra", 0, 1);
      else chk("rx slot", {11'h0, q.pop_front()}, {11'h0, RX_PAYLOAD_SLOT_OUT, RX_PAYLOAD_DATA_OUT});
    end
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    {RST_B_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, TX_PAYLOAD_WR_IN, run} = '0;
    {PADDR_IN, PWDATA_IN, TX_PAYLOAD_SLOT_IN, TX_PAYLOAD_DATA_IN} = '0;
    CE_IN = 1'b1;
    repeat (10) @(posedge CLK_IN);
    RST_B_IN <= 1'b1;
    apb(1'b0, tdmh_pkg::ADDR_IDLE, '0);
    chk("idle reset", 32'hFF, rd);
    apb(1'b0, 8'h40, '0);
    chk("unmapped", 32'h1, {30'h0, |rd, err});
    apb(1'b0, tdmh_pkg::ADDR_CTRL, '0);
    chk("ctrl reset", 32'h0, rd);
    idle = 8'(rnd());
    apb(1'b1, tdmh_pkg::ADDR_IDLE, {24'h0, idle});
    apb(1'b1, tdmh_pkg::ADDR_TX_EN, 32'h3);
    apb(1'b1, tdmh_pkg::ADDR_TX_LANE, 32'h2);
    apb(1'b1, tdmh_pkg::ADDR_RX_EN, 32'hB);
    apb(1'b1, tdmh_pkg::ADDR_RX_LANE, 32'h2);
    apb(1'b0, tdmh_pkg::ADDR_RX_LANE, '0);
    chk("rx lane reg", 32'h2, rd);
    TX_PAYLOAD_DATA_IN <= 16'(rnd());
    TX_PAYLOAD_WR_IN <= 1'b1;
    @(posedge CLK_IN);
    TX_PAYLOAD_WR_IN <= 1'b0;
    $display("test registers done");
    for (int f = 0; f < 10; f++) begin
      sl = f % 5;
      p = 8'hA5 ^ 8'(sl);
      q.push_back({5'(sl), 8'h0, (sl == 2 || sl == 4) ? idle : (sl == 1 ? ~p : p)});
    end
    run <= 1'b1;
    while (q.size() != 0) @(posedge CLK_IN);
    run <= 1'b0;
    chk("tx slot0", {24'h0, TX_PAYLOAD_DATA_IN[7:0]}, {24'h0, txb});
    chk("tx slot1 primary", 32'h0, {31'h0, oe1});
    $display("test highway done");
    RST_B_IN <= 1'b0;
    repeat (3) @(posedge CLK_IN);
    RST_B_IN <= 1'b1;
    @(posedge CLK_IN);
    chk("oe after reset", 32'h0, {31'h0, TX_LANE_PRIMARY_OE_OUT});
    repeat (400) @(posedge CLK_IN);
    $display("test reset done");
    print_verdict();
  end
endmodule
